// *** verilog/rsb_dev.sv ***
// device end: control fields, fifo clear timing, transfer modes, status
// assumes host strobes on the same clock; memory read data combinational
`timescale 1ns/10ps
`include "rsb_regs.svh"

// How it works
// - go bit starts drawing, clears itself
// - host dummy-reads memory before setting go
// - fifo cleared 64 cycles after dummy read
// - host waits go back to zero first
// - two-bit field selects double-buffer mode
// - two-bit field selects transfer mode
// - mode 01: memory-space writes go to memory
// - mode 11: register writes hit entry port
// - count loaded on entry, minus one per word
// - count zero returns mode field to normal
// - no ordinary memory access during transfers
// - host watches done flag for transfer end
// - host writes zeros to low reserved bits
// - done flag sticky until reset or software
// - no drawing while display reset held
module rsb_dev (
  input  wire logic     clk,
  input  wire logic     resetn,
  rsb_if.dev            bus,
  input  wire logic     display_reset,
  input  rsb_pkg::rsb_word_t ugm_rdata,
  output logic          ugm_we,
  output logic          ugm_re,
  output rsb_pkg::rsb_word_t ugm_addr,
  output rsb_pkg::rsb_word_t ugm_wdata,
  output logic          entry_we,
  output rsb_pkg::rsb_word_t entry_wdata,
  output logic          draw_start,
  output logic          fifo_clear,
  output logic [1:0]    dbuf_mode,
  output logic          xfer_active,
  output logic          xfer_done_flag,
  output logic          irq
);
  import rsb_pkg::*;

  rsb_dev_s q;
  rsb_dev_s d;
  logic     reg_wr;
  logic     reg_rd;
  logic     mem_wr;
  logic     mem_rd;
  logic     dma_on;
  logic [2:0] ra;

  assign reg_wr = bus.reg_chip_select & bus.wr;
  assign reg_rd = bus.reg_chip_select & bus.rd;
  assign mem_wr = bus.mem_chip_select & bus.wr;
  assign mem_rd = bus.mem_chip_select & bus.rd;
  assign ra     = bus.addr[`RSB_F_ADDR];
  assign dma_on = (q.xmode != RSB_XM_NORMAL);

  always_comb begin
    d            = q;
    d.ugm_we     = 1'b0;
    d.ugm_re     = 1'b0;
    d.entry_we   = 1'b0;
    d.draw_start = 1'b0;
    d.fifo_clear = 1'b0;
    d.mem_rsp    = 1'b0;
    d.rdata      = `RSB_CNT_RST;

    // fifo drain timer started by a memory read
    if (q.fill_busy) begin
      if (q.fill_cnt == `RSB_FILL_CYC - `RSB_FILL_ONE) begin
        d.fill_busy  = 1'b0;
        d.fifo_clear = 1'b1;
        d.fifo_clean = 1'b1;
      end else begin
        d.fill_cnt = q.fill_cnt + `RSB_FILL_ONE;
      end
    end

    // memory space
    if (mem_rd && !dma_on) begin
      // any memory read outside transfer modes counts as the dummy read and restarts the drain
      d.ugm_re     = 1'b1;
      d.ugm_addr   = bus.addr;
      d.mem_rsp    = 1'b1;
      d.fill_busy  = 1'b1;
      d.fill_cnt   = '0;
      d.fifo_clean = 1'b0;
    end
    if (mem_wr) begin
      case (q.xmode)
        RSB_XM_NORMAL: begin
          d.ugm_we    = 1'b1;
          d.ugm_addr  = bus.addr;
          d.ugm_wdata = bus.wdata;
        end
        RSB_XM_UGM: begin
          if (q.remain != `RSB_CNT_RST) begin
            d.ugm_we    = 1'b1;
            d.ugm_addr  = bus.addr;
            d.ugm_wdata = bus.wdata;
            d.remain    = q.remain - `RSB_WORD_ONE;
          end
        end
        default: begin
          // entry mode: memory locked out, write dropped
        end
      endcase
    end

    // register space writes
    if (reg_wr) begin
      if (q.xmode == RSB_XM_ENTRY) begin
        // every address lands on the entry port, no increment
        if (q.remain != `RSB_CNT_RST) begin
          d.entry_we    = 1'b1;
          d.entry_wdata = bus.wdata;
          d.remain      = q.remain - `RSB_WORD_ONE;
        end
      end else begin
        case (ra)
          `RSB_A_CTRL: begin
            if (bus.wdata[`RSB_F_DBUF] != RSB_DB_BAD) begin
              d.dbuf = rsb_dbuf_e'(bus.wdata[`RSB_F_DBUF]);
            end
            if (bus.wdata[`RSB_B_GO]) begin
              d.render_go = 1'b1;
            end
            case (bus.wdata[`RSB_F_XMODE])
              RSB_XM_NORMAL: begin
                d.xmode = RSB_XM_NORMAL;
              end
              RSB_XM_UGM, RSB_XM_ENTRY: begin
                if (!dma_on) begin
                  d.xmode  = rsb_xmode_e'(bus.wdata[`RSB_F_XMODE]);
                  d.remain = q.wcnt;
                  d.done   = 1'b0;
                end
              end
              default: begin
                // prohibited code leaves the mode unchanged
              end
            endcase
          end
          `RSB_A_WCNT: begin
            d.wcnt = bus.wdata;
          end
          `RSB_A_SCLR: begin
            if (bus.wdata[`RSB_B_DONE]) begin
              d.done = 1'b0;
            end
          end
          `RSB_A_IRQM: begin
            d.imask = bus.wdata[1:0];
          end
          `RSB_A_ENTRY: begin
            d.entry_we    = 1'b1;
            d.entry_wdata = bus.wdata;
          end
          default: begin
          end
        endcase
      end
    end

    // register space reads, answered next cycle
    if (reg_rd && q.xmode != RSB_XM_ENTRY) begin
      case (ra)
        `RSB_A_CTRL: begin
          d.rdata[`RSB_B_GO]    = q.render_go;
          d.rdata[`RSB_F_DBUF]  = q.dbuf;
          d.rdata[`RSB_F_XMODE] = q.xmode;
          d.rdata[`RSB_F_RSVD]  = `RSB_RSVD_0;
        end
        `RSB_A_WCNT: begin
          d.rdata = q.wcnt;
        end
        `RSB_A_STAT: begin
          d.rdata[`RSB_B_DONE] = q.done;
        end
        `RSB_A_IRQS: begin
          d.rdata[1:0] = q.istat;
          d.istat      = `RSB_IRQ_RST; // sets below win
        end
        `RSB_A_IRQM: begin
          d.rdata[1:0] = q.imask;
        end
        default: begin
        end
      endcase
    end

    // self-clearing comes last so it overrides any host write
    if (q.render_go && q.fifo_clean && !display_reset) begin
      d.draw_start        = 1'b1;
      d.render_go         = 1'b0;
      d.fifo_clean        = 1'b0;
      d.istat[`RSB_I_GO]  = 1'b1;
    end
    if (dma_on && q.remain == `RSB_CNT_RST) begin
      d.xmode              = RSB_XM_NORMAL;
      d.done               = 1'b1;
      d.istat[`RSB_I_DONE] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // memory read data passes straight through in the answer cycle
  assign bus.rdata     = q.mem_rsp ? ugm_rdata : q.rdata;
  assign ugm_we        = q.ugm_we;
  assign ugm_re        = q.ugm_re;
  assign ugm_addr      = q.ugm_addr;
  assign ugm_wdata     = q.ugm_wdata;
  assign entry_we      = q.entry_we;
  assign entry_wdata   = q.entry_wdata;
  assign draw_start    = q.draw_start;
  assign fifo_clear    = q.fifo_clear;
  assign dbuf_mode     = q.dbuf;
  assign xfer_active   = (q.xmode != RSB_XM_NORMAL);
  assign xfer_done_flag = q.done;
  assign irq           = |(q.istat & q.imask);
endmodule

// *** verilog/rsb_regs.svh ***
// register offsets, field positions and counts of the render start block
// assumes inclusion by bare name from the package and both ends
`ifndef RSB_REGS_SVH
`define RSB_REGS_SVH

// register space offsets (low three bits of the bus address)
`define RSB_A_CTRL   3'h0
`define RSB_A_WCNT   3'h1
`define RSB_A_STAT   3'h2
`define RSB_A_SCLR   3'h3
`define RSB_A_IRQS   3'h4
`define RSB_A_IRQM   3'h5
`define RSB_A_ENTRY  3'h6
`define RSB_F_ADDR   2:0

// control register fields
`define RSB_B_GO     8
`define RSB_F_DBUF   7:6
`define RSB_F_XMODE  5:4
`define RSB_F_RSVD   3:0
`define RSB_RSVD_0   4'h0

// status and interrupt fields
`define RSB_B_DONE   13
`define RSB_I_DONE   0
`define RSB_I_GO     1

// reset values and counts
`define RSB_CNT_RST  16'h0000
`define RSB_IRQ_RST  2'h0
`define RSB_FILL_W   7
`define RSB_FILL_CYC 7'h40
`define RSB_FILL_ONE 7'h01
`define RSB_WORD_ONE 16'h0001

`endif

// *** verilog/rsb_pkg.sv ***
// types shared by both ends of the render start and transfer block
// assumes rsb_regs.svh on the include path
package rsb_pkg;
  `include "rsb_regs.svh"

  typedef enum logic [1:0] {
    RSB_XM_NORMAL = 2'b00,
    RSB_XM_UGM    = 2'b01,
    RSB_XM_BAD    = 2'b10,
    RSB_XM_ENTRY  = 2'b11
  } rsb_xmode_e;

  typedef enum logic [1:0] {
    RSB_DB_AUTO_DISP = 2'b00,
    RSB_DB_AUTO_REND = 2'b01,
    RSB_DB_MAN_DISP  = 2'b10,
    RSB_DB_BAD       = 2'b11
  } rsb_dbuf_e;

  typedef enum logic [0:0] {
    RSB_HS_IDLE = 1'b0,
    RSB_HS_GOWR = 1'b1
  } rsb_hstate_e;

  typedef logic [15:0] rsb_word_t;

  typedef struct packed {
    logic                 render_go;
    rsb_dbuf_e            dbuf;
    rsb_xmode_e           xmode;
    rsb_word_t            wcnt;
    rsb_word_t            remain;
    logic                 done;
    logic                 fill_busy;
    logic [`RSB_FILL_W-1:0] fill_cnt;
    logic                 fifo_clean;
    logic [1:0]           istat;
    logic [1:0]           imask;
    rsb_word_t            rdata;
    logic                 mem_rsp;
    logic                 ugm_we;
    logic                 ugm_re;
    rsb_word_t            ugm_addr;
    rsb_word_t            ugm_wdata;
    logic                 entry_we;
    rsb_word_t            entry_wdata;
    logic                 draw_start;
    logic                 fifo_clear;
  } rsb_dev_s;

  typedef struct packed {
    rsb_hstate_e st;
    logic        reg_cs;
    logic        mem_cs;
    logic        wr;
    logic        rd;
    rsb_word_t   addr;
    rsb_word_t   wdata;
    rsb_word_t   pend;
    logic        rd_wait;
    logic [2:0]  rd_addr;
    logic        rd_reg;
    logic        rsp_valid;
    rsb_word_t   rsp_data;
    logic        refused;
    logic        go_seen;
    logic        done_seen;
  } rsb_host_s;
endpackage

// *** verilog/rsb_if.sv ***
// bus between the host cpu side and the render start device
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface rsb_if;
  logic        reg_chip_select;
  logic        mem_chip_select;
  logic        wr;
  logic        rd;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport host (
    output reg_chip_select,
    output mem_chip_select,
    output wr,
    output rd,
    output addr,
    output wdata,
    input  rdata
  );

  modport dev (
    input  reg_chip_select,
    input  mem_chip_select,
    input  wr,
    input  rd,
    input  addr,
    input  wdata,
    output rdata
  );
endinterface

// *** verilog/rsb_host.sv ***
// host end: turns user commands into bus cycles, guards control writes
// assumes the device on the same clock answers reads one cycle later
`timescale 1ns/10ps
`include "rsb_regs.svh"

module rsb_host (
  input  wire logic     clk,
  input  wire logic     resetn,
  rsb_if.host           bus,
  input  wire logic     cmd_wr,
  input  wire logic     cmd_rd,
  input  wire logic     cmd_mem,
  input  rsb_pkg::rsb_word_t cmd_addr,
  input  rsb_pkg::rsb_word_t cmd_wdata,
  output logic          cmd_busy,
  output logic          cmd_refused,
  output logic          rsp_valid,
  output rsb_pkg::rsb_word_t rsp_data,
  output logic          go_seen,
  output logic          done_seen
);
  import rsb_pkg::*;

  rsb_host_s q;
  rsb_host_s d;
  rsb_word_t w;

  always_comb begin
    d           = q;
    d.reg_cs    = 1'b0;
    d.mem_cs    = 1'b0;
    d.wr        = 1'b0;
    d.rd        = 1'b0;
    // reply stands the cycle after the strobe; the dummy read gets none
    d.rd_wait   = q.rd && (q.st == RSB_HS_IDLE);
    d.refused   = 1'b0;
    d.rsp_valid = q.rd_wait;
    if (q.rd) begin
      d.rd_addr = q.addr[`RSB_F_ADDR];
      d.rd_reg  = q.reg_cs;
    end
    w           = cmd_wdata;
    w[`RSB_F_RSVD] = `RSB_RSVD_0;
    if (q.rd_wait) begin
      d.rsp_data = bus.rdata;
      if (q.rd_reg && q.rd_addr == `RSB_A_STAT) begin
        d.done_seen = bus.rdata[`RSB_B_DONE];
      end
      if (q.rd_reg && q.rd_addr == `RSB_A_CTRL) begin
        d.go_seen = bus.rdata[`RSB_B_GO];
      end
    end
    case (q.st)
      RSB_HS_GOWR: begin
        d.reg_cs  = 1'b1;
        d.wr      = 1'b1;
        d.addr    = {13'h0000, `RSB_A_CTRL};
        d.wdata   = q.pend;
        d.go_seen = 1'b1;
        d.st      = RSB_HS_IDLE;
      end
      RSB_HS_IDLE: begin
        if (cmd_wr && !cmd_mem && cmd_addr[`RSB_F_ADDR] == `RSB_A_CTRL) begin
          if (w[`RSB_F_DBUF] == RSB_DB_BAD ||
              w[`RSB_F_XMODE] == RSB_XM_BAD) begin
            d.refused = 1'b1;
          end else if (w[`RSB_B_GO] && q.go_seen) begin
            d.refused = 1'b1;
          end else if (w[`RSB_B_GO]) begin
            // dummy read first so the device drains its fifo
            d.mem_cs = 1'b1;
            d.rd     = 1'b1;
            d.addr   = cmd_addr;
            d.pend   = w;
            d.st     = RSB_HS_GOWR;
          end else begin
            d.reg_cs = 1'b1;
            d.wr     = 1'b1;
            d.addr   = cmd_addr;
            d.wdata  = w;
          end
        end else if (cmd_wr || cmd_rd) begin
          d.reg_cs  = !cmd_mem;
          d.mem_cs  = cmd_mem;
          d.wr      = cmd_wr;
          d.rd      = cmd_rd && !cmd_wr;
          d.addr    = cmd_addr;
          d.wdata   = cmd_wdata;
        end
      end
      default: begin
        d.st = RSB_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.reg_chip_select = q.reg_cs;
  assign bus.mem_chip_select = q.mem_cs;
  assign bus.wr              = q.wr;
  assign bus.rd              = q.rd;
  assign bus.addr            = q.addr;
  assign bus.wdata           = q.wdata;
  assign cmd_busy            = (q.st == RSB_HS_GOWR);
  assign cmd_refused         = q.refused;
  assign rsp_valid           = q.rsp_valid;
  assign rsp_data            = q.rsp_data;
  assign go_seen             = q.go_seen;
  assign done_seen           = q.done_seen;
endmodule

// *** testbench/rsb_chk.sv ***
// checker: timing of the device end seen from the shared bus and its pins
// assumes instantiation beside rsb_if, one clock, resetn active low
`timescale 1ns/10ps
module rsb_chk (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic               reg_chip_select,
  input wire logic               mem_chip_select,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [15:0]        wdata,
  input wire logic               display_reset,
  input wire logic               ugm_we,
  input wire logic               ugm_re,
  input wire rsb_pkg::rsb_word_t ugm_wdata,
  input wire logic               entry_we,
  input wire rsb_pkg::rsb_word_t entry_wdata,
  input wire logic               draw_start,
  input wire logic               fifo_clear,
  input wire logic [1:0]         dbuf_mode,
  input wire logic               xfer_active,
  input wire logic               xfer_done_flag
);
  import rsb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_dummy_rd;
    (mem_chip_select && rd && !xfer_active) |=> ugm_re;
  endproperty
  a_dummy_rd: assert property (p_dummy_rd)
    else $error("memory read not passed to memory");
  // a restarted drain still ends 64 cycles after the last read
  property p_fill;
    fifo_clear |-> $past(ugm_re, 64);
  endproperty
  a_fill: assert property (p_fill)
    else $error("fifo clear not 64 cycles after read");
  property p_no_draw;
    draw_start |-> !$past(display_reset);
  endproperty
  a_no_draw: assert property (p_no_draw)
    else $error("drawing began under display reset");
  property p_dbuf;
    dbuf_mode != 2'b11;
  endproperty
  a_dbuf: assert property (p_dbuf)
    else $error("double buffer mode took a banned code");
  property p_rd_drop;
    (mem_chip_select && rd && xfer_active) |=> !ugm_re;
  endproperty
  a_rd_drop: assert property (p_rd_drop)
    else $error("memory read during transfer mode");
  property p_mem_wr;
    ugm_we |-> $past(mem_chip_select && wr) && ugm_wdata == $past(wdata);
  endproperty
  a_mem_wr: assert property (p_mem_wr)
    else $error("memory write without a bus write");
  property p_entry;
    entry_we |-> $past(reg_chip_select && wr) && entry_wdata == $past(wdata);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry port write without a bus write");
  property p_done_set;
    $rose(xfer_done_flag) |-> !xfer_active && $past(xfer_active);
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag without return to normal mode");
  property p_done_hold;
    $fell(xfer_done_flag) |-> $past(reg_chip_select && wr);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done flag dropped without a write");
  c_draw: cover property (draw_start);
  c_done: cover property ($rose(xfer_done_flag));
  c_entry: cover property (entry_we);
endmodule

// *** testbench/test_render_start_buffer_dma_ctrl.sv ***
// bench: host end and device end joined, driven from the host user port
// assumes both ends on clk; ugm read data made combinationally here
`timescale 1ns/10ps
`include "rsb_regs.svh"
module test_render_start_buffer_dma_ctrl;
  import rsb_pkg::*;
  logic       clk, resetn, cmd_wr, cmd_rd, cmd_mem, display_reset;
  rsb_word_t  cmd_addr, cmd_wdata, ugm_rdata, ugm_addr, ugm_wdata;
  rsb_word_t  entry_wdata, rsp_data;
  logic       ugm_we, ugm_re, entry_we, draw_start, fifo_clear, irq;
  logic       xfer_active, xfer_done_flag, cmd_refused, go_seen;
  logic       cmd_busy, rsp_valid, done_seen;
  logic [1:0] dbuf_mode;
  int         miscompares, checks_done, n_fc, n_ds, n_we, n_re, n_en, n_rf;
  int         n_rv, n_bz;

  rsb_if rsb_if_inst ();
  // address-dependent data so a stuck address shows up
  assign ugm_rdata = ugm_addr ^ 16'h5a5a;
  rsb_dev rsb_dev_inst (.clk(clk), .resetn(resetn), .bus(rsb_if_inst.dev),
    .display_reset(display_reset), .ugm_rdata(ugm_rdata), .ugm_we(ugm_we),
    .ugm_re(ugm_re), .ugm_addr(ugm_addr), .ugm_wdata(ugm_wdata),
    .entry_we(entry_we), .entry_wdata(entry_wdata), .draw_start(draw_start),
    .fifo_clear(fifo_clear), .dbuf_mode(dbuf_mode), .xfer_active(xfer_active),
    .xfer_done_flag(xfer_done_flag), .irq(irq));
  rsb_host rsb_host_inst (.clk(clk), .resetn(resetn), .bus(rsb_if_inst.host),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_mem(cmd_mem), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .cmd_refused(cmd_refused),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .go_seen(go_seen),
    .done_seen(done_seen));
  rsb_chk rsb_chk_inst (.clk(clk), .resetn(resetn),
    .reg_chip_select(rsb_if_inst.reg_chip_select),
    .mem_chip_select(rsb_if_inst.mem_chip_select), .wr(rsb_if_inst.wr),
    .rd(rsb_if_inst.rd), .wdata(rsb_if_inst.wdata),
    .display_reset(display_reset), .ugm_we(ugm_we), .ugm_re(ugm_re),
    .ugm_wdata(ugm_wdata), .entry_we(entry_we), .entry_wdata(entry_wdata),
    .draw_start(draw_start), .fifo_clear(fifo_clear), .dbuf_mode(dbuf_mode),
    .xfer_active(xfer_active), .xfer_done_flag(xfer_done_flag));

  always @(posedge clk) begin
    n_fc += (fifo_clear === 1'b1);
    n_ds += (draw_start === 1'b1);
    n_we += (ugm_we === 1'b1);
    n_re += (ugm_re === 1'b1);
    n_en += (entry_we === 1'b1);
    n_rf += (cmd_refused === 1'b1);
    n_rv += (rsp_valid === 1'b1);
    n_bz += (cmd_busy === 1'b1);
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one user command, then idle long enough for a go write or a read reply
  task automatic cmd(input logic w, input logic m, input rsb_word_t a,
                     input rsb_word_t d);
    @(posedge clk);
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_mem <= m;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic t_dbuf;
    int r;
    for (int m = 0; m < 3; m++) begin
      cmd(1, 0, `RSB_A_CTRL, rsb_word_t'(m << 6));
      chk(dbuf_mode, m);
    end
    r = n_rf;
    cmd(1, 0, `RSB_A_CTRL, 16'h00c0);
    chk(dbuf_mode, 2'b10);
    chk(n_rf - r, 1);
  endtask

  task automatic t_render;
    cmd(1, 0, `RSB_A_IRQM, 16'h0002);
    cmd(1, 0, `RSB_A_CTRL, 16'h0100);
    repeat (30) @(posedge clk);
    #1;
    chk(n_ds, 0);
    @(posedge clk);
    display_reset <= 1'b1;
    repeat (50) @(posedge clk);
    #1;
    chk(n_fc, 1);
    chk(n_ds, 0);
    @(posedge clk);
    display_reset <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(n_ds, 1);
    chk(irq, 1'b1);
    cmd(0, 0, `RSB_A_IRQS, 16'h0000);
    chk(rsp_data, 16'h0002);
    chk(irq, 1'b0);
    cmd(0, 0, `RSB_A_CTRL, 16'h0000);
    chk(rsp_data, 16'h0000);
    chk(go_seen, 1'b0);
  endtask

  task automatic t_ugm;
    int re, we;
    re = n_re;
    we = n_we;
    cmd(1, 0, `RSB_A_WCNT, 16'h0003);
    cmd(1, 0, `RSB_A_IRQM, 16'h0001);
    cmd(1, 0, `RSB_A_CTRL, 16'h0010);
    chk(xfer_active, 1'b1);
    cmd(0, 1, 16'h0040, 16'h0000);
    chk(n_re, re);
    for (int i = 0; i < 3; i++) begin
      cmd(1, 1, rsb_word_t'(16'h0100 + i), rsb_word_t'(16'hc0d0 + i));
      if (i == 1) chk(xfer_active, 1'b1);
    end
    chk(n_we - we, 3);
    chk(ugm_wdata, 16'hc0d2);
    chk(xfer_active, 1'b0);
    chk(irq, 1'b1);
    cmd(0, 0, `RSB_A_STAT, 16'h0000);
    chk(rsp_data[`RSB_B_DONE], 1'b1);
    chk(done_seen, 1'b1);
    chk(xfer_done_flag, 1'b1);
    cmd(0, 0, `RSB_A_IRQS, 16'h0000);
    chk(irq, 1'b0);
    cmd(1, 0, `RSB_A_SCLR, 16'h2000);
    chk(xfer_done_flag, 1'b0);
  endtask

  task automatic t_entry;
    int en, r;
    en = n_en;
    cmd(1, 0, `RSB_A_WCNT, 16'h0002);
    cmd(1, 0, `RSB_A_CTRL, 16'h0030);
    cmd(1, 0, 16'h0001, 16'h0a01);
    cmd(1, 0, 16'h0005, 16'h0a02);
    chk(n_en - en, 2);
    chk(entry_wdata, 16'h0a02);
    chk(xfer_active, 1'b0);
    cmd(0, 0, `RSB_A_CTRL, 16'h0000);
    chk(rsp_data[`RSB_F_XMODE], 2'b00);
    r = n_rf;
    cmd(1, 0, `RSB_A_CTRL, 16'h0020);
    chk(n_rf - r, 1);
    chk(xfer_active, 1'b0);
  endtask

  // normal-mode traffic, a second go refused, a zero count
  task automatic t_misc;
    int r, v, b, en, ds;
    r = n_rf;
    v = n_rv;
    b = n_bz;
    en = n_en;
    ds = n_ds;
    cmd(1, 1, 16'h0077, 16'hbeef);
    chk(ugm_addr, 16'h0077);
    chk(ugm_wdata, 16'hbeef);
    cmd(1, 0, `RSB_A_ENTRY, 16'h0e0e);
    chk(n_en - en, 1);
    chk(entry_wdata, 16'h0e0e);
    cmd(0, 1, 16'h0123, 16'h0000);
    chk(rsp_data, 16'h0123 ^ 16'h5a5a);
    chk(n_rv - v, 1);
    cmd(1, 0, `RSB_A_CTRL, 16'h0100);
    chk(go_seen, 1'b1);
    chk(n_bz - b, 1);
    chk(n_rv - v, 1);
    cmd(1, 0, `RSB_A_CTRL, 16'h0100);
    chk(n_rf - r, 1);
    repeat (60) @(posedge clk);
    #1;
    chk(n_ds - ds, 1);
    cmd(0, 0, `RSB_A_CTRL, 16'h0000);
    chk(go_seen, 1'b0);
    cmd(1, 0, `RSB_A_SCLR, 16'h2000);
    cmd(0, 0, `RSB_A_STAT, 16'h0000);
    chk(done_seen, 1'b0);
    cmd(1, 0, `RSB_A_WCNT, 16'h0000);
    cmd(1, 0, `RSB_A_CTRL, 16'h0010);
    chk(xfer_active, 1'b0);
    chk(xfer_done_flag, 1'b1);
  endtask

  task automatic stop_test;
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {resetn, cmd_wr, cmd_rd, cmd_mem, display_reset} = '0;
    {cmd_addr, cmd_wdata} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    chk(dbuf_mode, 2'b00);
    chk(xfer_active, 1'b0);
    t_dbuf();
    t_render();
    t_ugm();
    t_entry();
    t_misc();
    stop_test();
  end

  // whole run needs about 400 cycles; this leaves a wide margin
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule
